/* File: mbac_defs.svh */
// constants of the mode based access checker: address map, reset values
// assumes inclusion by bare name from the package only
`ifndef MBAC_DEFS_SVH
`define MBAC_DEFS_SVH

// virtual address: top bits pick the segment window, the rest is offset
`define MBAC_VA_W        16
`define MBAC_SEG_MSB     15
`define MBAC_SEG_LSB     13
`define MBAC_OFS_W       13
`define MBAC_SEG_N       8
`define MBAC_SFR_W       8

// register space: group start offsets and counts of existing registers
`define MBAC_SYS_LO      8'h00
`define MBAC_SYS_CNT     8'h10
`define MBAC_SEG_LO      8'h20
`define MBAC_SEG_CNT     8'h10
`define MBAC_ACC_LO      8'h40
`define MBAC_ACC_CNT     8'h02
`define MBAC_TEST_LO     8'h50
`define MBAC_TEST_CNT    8'h08
`define MBAC_HW_LO       8'h60
`define MBAC_HW_CNT      8'h18
`define MBAC_KEY_CNT     8'h10

// system management registers that user mode may reach
`define MBAC_SYS_EVAL    8'h00
`define MBAC_SYS_WDOG    8'h01
`define MBAC_SYS_DBASE   8'h02

// access config offsets and enable bits
`define MBAC_ACC_SEGEN   1'b0
`define MBAC_GRP_TEST    0
`define MBAC_GRP_HW      1

// reset values
`define MBAC_BASE_RST    16'h0000
`define MBAC_SIZE_RST    16'h2000
`define MBAC_CALL_SIZE   16'h0100
`define MBAC_SEGEN_RST   8'hff
`define MBAC_GRPEN_RST   2'h3

`endif

/* File: mbac_pkg.sv */
// types of the mode based access checker
// assumes mbac_defs.svh sits in the same folder
package mbac_pkg;
`include "mbac_defs.svh"

   typedef enum logic [1:0] {
      mbac_user_mode         = 2'h0,
      mbac_system_mode       = 2'h1,
      mbac_super_system_mode = 2'h2
   } mbac_mode_type;

   typedef enum logic [1:0] {
      mbac_op_read  = 2'h0,
      mbac_op_write = 2'h1,
      mbac_op_exec  = 2'h2
   } mbac_op_type;

   typedef enum logic [2:0] {
      mbac_sys_rom_constants    = 3'h0,
      mbac_shared_rom_constants = 3'h1,
      mbac_call_entry_table     = 3'h2,
      mbac_sys_code_region      = 3'h3,
      mbac_shared_code_region   = 3'h4,
      mbac_user_flash_constants = 3'h5,
      mbac_sys_ram_region       = 3'h6,
      mbac_user_ram_region      = 3'h7
   } mbac_seg_type;

   typedef enum logic [1:0] {
      mbac_mem_rom    = 2'h0,
      mbac_mem_ram    = 2'h1,
      mbac_mem_eeprom = 2'h2,
      mbac_mem_flash  = 2'h3
   } mbac_mem_type;

   typedef enum logic [2:0] {
      mbac_grp_none     = 3'h0,
      mbac_grp_sys_mgmt = 3'h1,
      mbac_grp_seg_cfg  = 3'h2,
      mbac_grp_acc_cfg  = 3'h3,
      mbac_grp_test     = 3'h4,
      mbac_grp_hw_comp  = 3'h5
   } mbac_group_type;

   typedef enum logic [2:0] {
      mbac_cause_none        = 3'h0,
      mbac_cause_mem_denied  = 3'h1,
      mbac_cause_mem_missing = 3'h2,
      mbac_cause_sfr_denied  = 3'h3,
      mbac_cause_sfr_missing = 3'h4
   } mbac_cause_type;

endpackage : mbac_pkg

/* File: mbac_translate.sv */
// address translation unit: virtual address to segment and physical address
// assumes base and size settings come from the segment config registers
`timescale 1ns/1ps
`default_nettype none
module mbac_translate
   import mbac_pkg::*;
(
   input  wire logic [`MBAC_VA_W-1:0]                  vaddr_in,
   input  wire logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] base_in,
   input  wire logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] size_in,
   output logic      [2:0]                             seg_out,
   output logic      [`MBAC_VA_W-1:0]                  paddr_out,
   output logic                                        exists_out
);
   logic [`MBAC_VA_W-1:0] offset;

   assign seg_out    = vaddr_in[`MBAC_SEG_MSB:`MBAC_SEG_LSB];
   assign offset     = {{(`MBAC_VA_W-`MBAC_OFS_W){1'b0}}, vaddr_in[`MBAC_OFS_W-1:0]};
   // every access is relocated by the segment base [R1]
   assign paddr_out  = base_in[seg_out] + offset;
   // offsets past the configured size address nothing [R3]
   assign exists_out = offset < size_in[seg_out];
endmodule : mbac_translate
`default_nettype wire

/* File: mbac_permit.sv */
// grant decision per privilege mode for memory and register accesses
// assumes mode, operation and address stand in the same cycle
`timescale 1ns/1ps
`default_nettype none
module mbac_permit
   import mbac_pkg::*;
(
   input  wire logic [1:0]             mode_in,
   input  wire logic [1:0]             op_in,
   input  wire logic                   sfr_in,
   input  wire logic [2:0]             seg_in,
   input  wire logic [`MBAC_SEG_N-1:0] seg_en_in,
   input  wire logic [`MBAC_SFR_W-1:0] sfr_addr_in,
   input  wire logic [1:0]             grp_en_in,
   output logic                        allow_out,
   output logic      [2:0]             group_out
);
   function automatic logic in_grp(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] cnt);
      in_grp = (a >= lo) && (a < 8'(lo + cnt));
   endfunction : in_grp

   function automatic mbac_group_type sfr_group(input logic [7:0] a);
      if (in_grp(a, `MBAC_SYS_LO, `MBAC_SYS_CNT)) begin
         sfr_group = mbac_grp_sys_mgmt;
      end else if (in_grp(a, `MBAC_SEG_LO, `MBAC_SEG_CNT)) begin
         sfr_group = mbac_grp_seg_cfg;
      end else if (in_grp(a, `MBAC_ACC_LO, `MBAC_ACC_CNT)) begin
         sfr_group = mbac_grp_acc_cfg;
      end else if (in_grp(a, `MBAC_TEST_LO, `MBAC_TEST_CNT)) begin
         sfr_group = mbac_grp_test;
      end else if (in_grp(a, `MBAC_HW_LO, `MBAC_HW_CNT)) begin
         sfr_group = mbac_grp_hw_comp;
      end else begin
         sfr_group = mbac_grp_none;
      end
   endfunction : sfr_group

   // memory grant table; anything not listed is refused [R22]
   function automatic logic mem_ok(input logic [1:0] m, input logic [2:0] s,
                                   input logic [1:0] o);
      logic rd;
      logic wr;
      logic ex;
      logic priv;
      rd     = o == mbac_op_read;
      wr     = o == mbac_op_write;
      ex     = o == mbac_op_exec;
      priv   = (m == mbac_super_system_mode) || (m == mbac_system_mode);
      mem_ok = 1'b0;
      case (s)
         mbac_sys_rom_constants:    mem_ok = priv && rd;              // [R13] [R17]
         mbac_shared_rom_constants: mem_ok = (priv || m == mbac_user_mode) && rd; // [R13] [R17]
         mbac_call_entry_table:     mem_ok = priv && ex;              // [R14] [R18]
         mbac_sys_code_region:      mem_ok = priv && ex;              // [R14] [R18]
         mbac_shared_code_region:   mem_ok = (priv || m == mbac_user_mode) && ex; // [R14]
         mbac_user_flash_constants: mem_ok = priv && rd;              // [R15]
         mbac_sys_ram_region:       mem_ok = priv && (rd || wr);      // [R16]
         mbac_user_ram_region:      mem_ok = (priv || m == mbac_user_mode) && (rd || wr); // [R16]
         default:                   mem_ok = 1'b0;
      endcase
   endfunction : mem_ok

   logic super_system_mode;
   logic sm;
   logic um;
   logic rdwr;
   logic named;
   logic key;

   assign super_system_mode       = mode_in == mbac_super_system_mode;
   assign sm        = mode_in == mbac_system_mode;
   assign um        = mode_in == mbac_user_mode;
   assign rdwr      = (op_in == mbac_op_read) || (op_in == mbac_op_write);
   assign group_out = sfr_group(sfr_addr_in);
   assign named     = (sfr_addr_in == `MBAC_SYS_EVAL) || (sfr_addr_in == `MBAC_SYS_WDOG)
                      || (sfr_addr_in == `MBAC_SYS_DBASE);
   assign key       = in_grp(sfr_addr_in, `MBAC_HW_LO, `MBAC_KEY_CNT);

   always_comb begin
      allow_out = 1'b0;
      if (!sfr_in) begin
         // segment enables gate every memory grant [R8] [R10]
         allow_out = mem_ok(mode_in, seg_in, op_in) && seg_en_in[seg_in];   // [R2] [R4]
      end else if (rdwr) begin
         // each register decided by address and mode [R5] [R7]
         case (group_out)
            mbac_grp_sys_mgmt: allow_out = super_system_mode || sm || (um && named);      // [R19]
            mbac_grp_seg_cfg:  allow_out = super_system_mode || sm;                       // [R19]
            mbac_grp_acc_cfg:  allow_out = super_system_mode;                             // [R10]
            mbac_grp_test:     allow_out = super_system_mode && grp_en_in[`MBAC_GRP_TEST]; // [R11] [R20]
            mbac_grp_hw_comp:  allow_out = (super_system_mode || sm || um) && grp_en_in[`MBAC_GRP_HW]
                                           && !(key && op_in == mbac_op_read); // [R12] [R21]
            default:           allow_out = 1'b0;                            // [R6]
         endcase
      end
   end
endmodule : mbac_permit
`default_nettype wire

/* File: mbac_checker.sv */
// mode based access checker: sits between the core and memories and registers
// assumes the core presents mode, operation and address in one cycle;
// every access except a granted config register write is answered one clock later, forwarded, read back or turned into a reset
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] translate every virtual address before memory
// [R2] check mode permission before access proceeds
// [R3] denied or missing memory access resets
// [R4] policy covers all code, memories, operations
// [R5] police every register access by mode
// [R6] denied or missing register access resets
// [R7] register control covers every register operation
// [R8] grants use management and segment settings
// [R9] segment group holds base and size
// [R10] access group holds segment and group enables
// [R11] test register group with own permission
// [R12] coprocessor registers checked as one group
// [R13] super-system reads system and shared constants
// [R14] super-system fetches table, system, shared code
// [R15] super-system reads user flash constants
// [R16] super-system reads and writes both RAMs
// [R17] system mode reads system and shared constants
// [R18] system mode fetches table and system code
// [R19] user mode: coprocessors and named registers only
// [R20] test group reachable in super-system only
// [R21] key registers never readable
// [R22] uncovered combinations refused and reset
// [R23] core presents mode with each request
module mbac_checker
   import mbac_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    arst_n_in,
   input  wire logic                    req_valid_in,
   input  wire logic                    req_sfr_in,
   input  wire logic [1:0]              req_op_in,
   input  wire logic [1:0]              req_mode_in,
   input  wire logic [`MBAC_VA_W-1:0]   req_addr_in,
   input  wire logic [`MBAC_VA_W-1:0]   req_wdata_in,
   output logic                         mem_valid_out,
   output logic      [1:0]              mem_sel_out,
   output logic                         mem_write_out,
   output logic                         mem_fetch_out,
   output logic      [`MBAC_VA_W-1:0]   mem_addr_out,
   output logic      [`MBAC_VA_W-1:0]   mem_wdata_out,
   output logic                         sfr_valid_out,
   output logic                         sfr_write_out,
   output logic      [`MBAC_SFR_W-1:0]  sfr_addr_out,
   output logic      [`MBAC_VA_W-1:0]   sfr_wdata_out,
   output logic                         cfg_rdata_valid_out,
   output logic      [`MBAC_VA_W-1:0]   cfg_rdata_out,
   output logic                         sec_reset_out,
   output logic                         viol_out,
   output logic      [2:0]              viol_cause_out,
   output logic      [`MBAC_VA_W-1:0]   viol_addr_out
);
   // segment and access configuration
   logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] seg_base;
   logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] seg_size;
   logic [`MBAC_SEG_N-1:0]                 seg_en;
   logic [1:0]                             grp_en;
   logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] next_seg_base;
   logic [`MBAC_SEG_N-1:0][`MBAC_VA_W-1:0] next_seg_size;
   logic [`MBAC_SEG_N-1:0]                 next_seg_en;
   logic [1:0]                             next_grp_en;

   // next values of the registered outputs
   logic                    next_mem_valid;
   logic [1:0]              next_mem_sel;
   logic                    next_mem_write;
   logic                    next_mem_fetch;
   logic [`MBAC_VA_W-1:0]   next_mem_addr;
   logic [`MBAC_VA_W-1:0]   next_mem_wdata;
   logic                    next_sfr_valid;
   logic                    next_sfr_write;
   logic [`MBAC_SFR_W-1:0]  next_sfr_addr;
   logic [`MBAC_VA_W-1:0]   next_sfr_wdata;
   logic                    next_cfg_rdata_valid;
   logic [`MBAC_VA_W-1:0]   next_cfg_rdata;
   logic                    next_sec_reset;
   logic                    next_viol;
   logic [2:0]              next_viol_cause;
   logic [`MBAC_VA_W-1:0]   next_viol_addr;

   // decode results
   logic [2:0]              seg;
   logic [`MBAC_VA_W-1:0]   paddr;
   logic                    mem_exists;
   logic                    allow;
   logic [2:0]              group;
   logic [`MBAC_SFR_W-1:0]  sfr_addr;
   logic [3:0]              cfg_idx;
   logic                    internal;
   logic                    is_write;
   logic                    grant;
   logic [2:0]              cause;

   function automatic mbac_mem_type seg_memory(input logic [2:0] s);
      case (s)
         mbac_user_flash_constants: seg_memory = mbac_mem_flash;
         mbac_sys_ram_region:       seg_memory = mbac_mem_ram;
         mbac_user_ram_region:      seg_memory = mbac_mem_ram;
         default:                   seg_memory = mbac_mem_rom;
      endcase
   endfunction : seg_memory

   assign sfr_addr = req_addr_in[`MBAC_SFR_W-1:0];
   assign is_write = req_op_in == mbac_op_write;
   assign cfg_idx  = 4'(sfr_addr - `MBAC_SEG_LO);
   assign internal = (group == mbac_grp_seg_cfg) || (group == mbac_grp_acc_cfg);

   mbac_translate u_translate (
      .vaddr_in   (req_addr_in),
      .base_in    (seg_base),
      .size_in    (seg_size),
      .seg_out    (seg),
      .paddr_out  (paddr),
      .exists_out (mem_exists)
   );

   // the core supplies the mode in the request cycle [R23]
   mbac_permit u_permit (
      .mode_in     (req_mode_in),
      .op_in       (req_op_in),
      .sfr_in      (req_sfr_in),
      .seg_in      (seg),
      .seg_en_in   (seg_en),
      .sfr_addr_in (sfr_addr),
      .grp_en_in   (grp_en),
      .allow_out   (allow),
      .group_out   (group)
   );

   // forwarded only if it exists and is allowed [R4] [R7]
   always_comb begin
      cause = mbac_cause_none;
      if (!req_sfr_in) begin
         if (!mem_exists) begin
            cause = mbac_cause_mem_missing;          // [R3]
         end else if (!allow) begin
            cause = mbac_cause_mem_denied;           // [R3] [R22]
         end
      end else begin
         if (group == mbac_grp_none) begin
            cause = mbac_cause_sfr_missing;          // [R6]
         end else if (!allow) begin
            cause = mbac_cause_sfr_denied;           // [R6] [R22]
         end
      end
      grant = req_valid_in && (cause == mbac_cause_none);
   end

   // configuration registers, written only by granted accesses
   always_comb begin
      next_seg_base = seg_base;
      next_seg_size = seg_size;
      next_seg_en   = seg_en;
      next_grp_en   = grp_en;
      if (grant && req_sfr_in && is_write) begin
         if (group == mbac_grp_seg_cfg) begin
            // even index base, odd index size [R9]
            if (!cfg_idx[0]) begin
               next_seg_base[cfg_idx[3:1]] = req_wdata_in;
            end else if (cfg_idx[3:1] != mbac_call_entry_table) begin
               next_seg_size[cfg_idx[3:1]] = req_wdata_in;
            end
         end else if (group == mbac_grp_acc_cfg) begin
            if (sfr_addr[0] == `MBAC_ACC_SEGEN) begin
               next_seg_en = req_wdata_in[`MBAC_SEG_N-1:0];  // [R10]
            end else begin
               next_grp_en = req_wdata_in[1:0];              // [R10]
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < `MBAC_SEG_N; i++) begin
            seg_base[i] <= `MBAC_BASE_RST;
            seg_size[i] <= `MBAC_SIZE_RST;
         end
         seg_size[mbac_call_entry_table] <= `MBAC_CALL_SIZE;
         seg_en <= `MBAC_SEGEN_RST;
         grp_en <= `MBAC_GRPEN_RST;
      end else begin
         seg_base <= next_seg_base;
         seg_size <= next_seg_size;
         seg_en   <= next_seg_en;
         grp_en   <= next_grp_en;
      end
   end

   // forwarding, read back and violation capture
   always_comb begin
      next_mem_valid       = 1'b0;
      next_mem_sel         = mem_sel_out;
      next_mem_write       = 1'b0;
      next_mem_fetch       = 1'b0;
      next_mem_addr        = mem_addr_out;
      next_mem_wdata       = mem_wdata_out;
      next_sfr_valid       = 1'b0;
      next_sfr_write       = 1'b0;
      next_sfr_addr        = sfr_addr_out;
      next_sfr_wdata       = sfr_wdata_out;
      next_cfg_rdata_valid = 1'b0;
      next_cfg_rdata       = cfg_rdata_out;
      next_sec_reset       = 1'b0;
      next_viol            = viol_out;
      next_viol_cause      = viol_cause_out;
      next_viol_addr       = viol_addr_out;
      if (grant && !req_sfr_in) begin
         // only the physical address reaches memory [R1] [R2]
         next_mem_valid = 1'b1;
         next_mem_sel   = seg_memory(seg);
         next_mem_write = is_write;
         next_mem_fetch = req_op_in == mbac_op_exec;
         next_mem_addr  = paddr;
         next_mem_wdata = req_wdata_in;
      end else if (grant && !internal) begin
         next_sfr_valid = 1'b1;                                 // [R5]
         next_sfr_write = is_write;
         next_sfr_addr  = sfr_addr;
         next_sfr_wdata = req_wdata_in;
      end else if (grant && !is_write) begin
         next_cfg_rdata_valid = 1'b1;
         if (group == mbac_grp_seg_cfg) begin
            next_cfg_rdata = cfg_idx[0] ? seg_size[cfg_idx[3:1]]
                                        : seg_base[cfg_idx[3:1]];   // [R9]
         end else if (sfr_addr[0] == `MBAC_ACC_SEGEN) begin
            next_cfg_rdata = {{(`MBAC_VA_W-`MBAC_SEG_N){1'b0}}, seg_en};
         end else begin
            next_cfg_rdata = {{(`MBAC_VA_W-2){1'b0}}, grp_en};
         end
      end else if (req_valid_in && !grant) begin
         // refused or missing: pulse security reset [R3] [R6] [R22]
         next_sec_reset = 1'b1;
         if (!viol_out) begin
            next_viol       = 1'b1;
            next_viol_cause = cause;
            next_viol_addr  = req_addr_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_valid_out       <= 1'b0;
         mem_sel_out         <= 2'h0;
         mem_write_out       <= 1'b0;
         mem_fetch_out       <= 1'b0;
         mem_addr_out        <= 16'h0000;
         mem_wdata_out       <= 16'h0000;
         sfr_valid_out       <= 1'b0;
         sfr_write_out       <= 1'b0;
         sfr_addr_out        <= 8'h00;
         sfr_wdata_out       <= 16'h0000;
         cfg_rdata_valid_out <= 1'b0;
         cfg_rdata_out       <= 16'h0000;
         sec_reset_out       <= 1'b0;
         viol_out            <= 1'b0;
         viol_cause_out      <= 3'h0;
         viol_addr_out       <= 16'h0000;
      end else begin
         mem_valid_out       <= next_mem_valid;
         mem_sel_out         <= next_mem_sel;
         mem_write_out       <= next_mem_write;
         mem_fetch_out       <= next_mem_fetch;
         mem_addr_out        <= next_mem_addr;
         mem_wdata_out       <= next_mem_wdata;
         sfr_valid_out       <= next_sfr_valid;
         sfr_write_out       <= next_sfr_write;
         sfr_addr_out        <= next_sfr_addr;
         sfr_wdata_out       <= next_sfr_wdata;
         cfg_rdata_valid_out <= next_cfg_rdata_valid;
         cfg_rdata_out       <= next_cfg_rdata;
         sec_reset_out       <= next_sec_reset;
         viol_out            <= next_viol;
         viol_cause_out      <= next_viol_cause;
         viol_addr_out       <= next_viol_addr;
      end
   end
endmodule : mbac_checker
`default_nettype wire

/* File: mbac_monitor.sv */
// port assertions for the access checker
// assumes a bind from the bench top, one clock
`timescale 1ns/1ps
`default_nettype none
module mbac_monitor (
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   input wire logic        req_valid_in,
   input wire logic        req_sfr_in,
   input wire logic [1:0]  req_op_in,
   input wire logic [1:0]  req_mode_in,
   input wire logic [15:0] req_addr_in,
   input wire logic [15:0] req_wdata_in,
   input wire logic        mem_valid_out,
   input wire logic        mem_write_out,
   input wire logic        mem_fetch_out,
   input wire logic [15:0] mem_wdata_out,
   input wire logic        sfr_valid_out,
   input wire logic        cfg_rdata_valid_out,
   input wire logic        sec_reset_out,
   input wire logic        viol_out,
   input wire logic [2:0]  viol_cause_out,
   input wire logic [15:0] viol_addr_out
);
   wire logic [3:0] ans = {mem_valid_out, sfr_valid_out, cfg_rdata_valid_out, sec_reset_out};
   wire logic       rq  = req_valid_in & req_sfr_in;
   wire logic [7:0] ra  = req_addr_in[7:0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_one_answer: assert property ($onehot0(ans))
      else $error("two answers");
   a_no_idle_answer: assert property (|ans |-> $past(req_valid_in))
      else $error("stray answer");
   a_sfr_exec_refused: assert property (rq && req_op_in == 2'h2 |=> sec_reset_out)
      else $error("sfr exec granted");
   a_sfr_missing: assert property (rq && ra[7] |=> sec_reset_out)
      else $error("sfr missing granted");
   a_test_group_ssm: assert property (rq && req_mode_in != 2'h2 && ra[7:3] == 5'h0a |=> sec_reset_out)
      else $error("test group granted");
   a_key_read_refused: assert property (rq && req_op_in == 2'h0 && ra[7:4] == 4'h6 |=> sec_reset_out)
      else $error("key read granted");
   a_user_write_refused: assert property (req_valid_in && !req_sfr_in && req_mode_in == 2'h0
      && req_op_in == 2'h1 && req_addr_in[15:13] != 3'h7 |=> sec_reset_out)
      else $error("user write granted");
   a_fetch_kind: assert property (mem_fetch_out |-> mem_valid_out && $past(req_op_in) == 2'h2)
      else $error("stray fetch");
   a_write_data: assert property (mem_write_out |-> mem_valid_out && mem_wdata_out == $past(req_wdata_in))
      else $error("bad write data");
   a_viol_sticky: assert property (viol_out |=> viol_out && $stable(viol_cause_out) && $stable(viol_addr_out))
      else $error("record changed");
   a_viol_with_reset: assert property (sec_reset_out |-> viol_out)
      else $error("reset without flag");
endmodule : mbac_monitor
`default_nettype wire

/* File: mbac_cpu_model.sv */
// core model: presents one access per call, mode alongside
// assumes the caller releases the bus after the answer edge
`timescale 1ns/1ps
`default_nettype none
module mbac_cpu_model (
   input  wire logic        clk_in,
   output var  logic        req_valid_out = 1'b0,
   output var  logic        req_sfr_out = 1'b0,
   output var  logic [1:0]  req_op_out = 2'h0,
   output var  logic [1:0]  req_mode_out = 2'h0,
   output var  logic [15:0] req_addr_out = 16'h0000,
   output var  logic [15:0] req_wdata_out = 16'h0000
);
   task automatic issue(input logic [1:0] mode, input logic [1:0] op, input logic sfr,
                        input logic [15:0] addr, input logic [15:0] wd);
      @(posedge clk_in);
      req_valid_out <= 1'b1;
      req_mode_out  <= mode;
      req_op_out    <= op;
      req_sfr_out   <= sfr;
      req_addr_out  <= addr;
      req_wdata_out <= wd;
   endtask : issue
   task automatic release_bus();
      req_valid_out <= 1'b0;
      req_addr_out  <= ~req_addr_out;
      req_wdata_out <= ~req_wdata_out;
   endtask : release_bus
endmodule : mbac_cpu_model
`default_nettype wire

/* File: mbac_tb.sv */
// self-checking bench of the access checker
// assumes the package and models compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_in, arst_n_in, req_valid_in, req_sfr_in, mem_valid_out, mem_write_out;
   logic mem_fetch_out, sfr_valid_out, cfg_rdata_valid_out, sec_reset_out, viol_out;
   logic [1:0]  req_op_in, req_mode_in;
   logic [2:0]  viol_cause_out;
   logic [15:0] req_addr_in, req_wdata_in, mem_addr_out, cfg_rdata_out, viol_addr_out;
   int failures, checks_done;
   localparam logic [3:0] M = 4'h8, S = 4'h4, C = 4'h2, X = 4'h1, N = 4'h0;
   mbac_cpu_model u_cpu (.clk_in, .req_valid_out(req_valid_in), .req_sfr_out(req_sfr_in),
      .req_op_out(req_op_in), .req_mode_out(req_mode_in), .req_addr_out(req_addr_in),
      .req_wdata_out(req_wdata_in));
   mbac_checker u_dut (.clk_in, .arst_n_in, .req_valid_in, .req_sfr_in, .req_op_in, .req_mode_in,
      .req_addr_in, .req_wdata_in, .mem_valid_out, .mem_sel_out(), .mem_write_out, .mem_fetch_out,
      .mem_addr_out, .mem_wdata_out(), .sfr_valid_out, .sfr_write_out(), .sfr_addr_out(),
      .sfr_wdata_out(), .cfg_rdata_valid_out, .cfg_rdata_out, .sec_reset_out, .viol_out,
      .viol_cause_out, .viol_addr_out);
   task automatic final_report();
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one request, answer judged one edge later
   task automatic access(input logic [1:0] mode, input logic [1:0] op, input logic sfr,
                         input logic [15:0] addr, input logic [15:0] wd, input logic [3:0] exp);
      u_cpu.issue(mode, op, sfr, addr, wd);
      @(posedge clk_in);
      u_cpu.release_bus();
      #1 check({12'h0, mem_valid_out, sfr_valid_out, cfg_rdata_valid_out, sec_reset_out}, {12'h0, exp});
   endtask : access
   task automatic do_reset();
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
   endtask : do_reset
   task automatic t_reset_state();
      check({13'h0, viol_cause_out}, 16'h0000);
      access(2'h2, 2'h0, 1'b1, 16'h0021, 16'h0, C);
      check(cfg_rdata_out, 16'h2000);
      access(2'h2, 2'h0, 1'b1, 16'h0025, 16'h0, C);
      check(cfg_rdata_out, 16'h0100);
      access(2'h2, 2'h0, 1'b1, 16'h0041, 16'h0, C);
      check(cfg_rdata_out, 16'h0003);
   endtask : t_reset_state
   task automatic t_mem_matrix();
      logic g;
      for (int m = 0; m < 3; m++) for (int s = 0; s < 8; s++) for (int o = 0; o < 3; o++) begin
         if (m > 0) g = (o == 0 && s inside {0, 1, 5}) || (o == 2 && s inside {2, 3, 4}) || (o != 2 && s > 5);
         else g = (o == 0 && s == 1) || (o == 2 && s == 4) || (o != 2 && s == 7);
         access(m[1:0], o[1:0], 1'b0, {s[2:0], 13'h4}, 16'h5a5a, g ? M : X);
         if (g) check({mem_fetch_out, mem_write_out, mem_addr_out[13:0]}, {o == 2, o == 1, 14'h4});
      end
      access(2'h3, 2'h0, 1'b0, 16'h0004, 16'h0, X);
      access(2'h2, 2'h3, 1'b0, 16'h0004, 16'h0, X);
      check({viol_cause_out, viol_addr_out[12:0]}, 16'h2004);
   endtask : t_mem_matrix
   task automatic t_segment_cfg();
      do_reset();
      access(2'h2, 2'h1, 1'b1, 16'h002f, 16'h0010, N);
      access(2'h2, 2'h1, 1'b1, 16'h002e, 16'h1000, N);
      access(2'h0, 2'h0, 1'b0, 16'he00f, 16'h0, M);
      check(mem_addr_out, 16'h100f);
      access(2'h0, 2'h0, 1'b0, 16'he010, 16'h0, X);
      check({13'h0, viol_cause_out}, 16'h0002);
      access(2'h2, 2'h1, 1'b1, 16'h0040, 16'h00fe, N);
      access(2'h2, 2'h0, 1'b0, 16'h0004, 16'h0, X);
   endtask : t_segment_cfg
   task automatic t_register_policy();
      logic [15:0] tbl [13] = '{16'h4054, 16'h0051, 16'h1024, 16'ha051, 16'h8504, 16'h4501,
         16'h1704, 16'h8601, 16'h9644, 16'h4401, 16'h8181, 16'h0211, 16'h8402};
      do_reset();
      foreach (tbl[i]) access(tbl[i][15:14], tbl[i][13:12], 1'b1, {8'h0, tbl[i][11:4]}, 16'h0, tbl[i][3:0]);
      check({13'h0, viol_cause_out}, 16'h0003);
      access(2'h2, 2'h1, 1'b1, 16'h0041, 16'h0000, N);
      access(2'h0, 2'h1, 1'b1, 16'h0070, 16'h0, X);
      access(2'h2, 2'h0, 1'b1, 16'h0050, 16'h0, X);
   endtask : t_register_policy
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      #200us;
      failures++;
      final_report();
   end
   initial begin
      arst_n_in = 1'b0;
      failures = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_reset_state();
      t_mem_matrix();
      t_segment_cfg();
      t_register_policy();
      final_report();
   end
endmodule : testbench
bind mbac_checker mbac_monitor u_mon (.*);
`default_nettype wire
